// File: design/lcgs_pkg.sv
// constants for the logic cell gate-select block
package lcgs_pkg;
   localparam int unsigned LCGS_ADDR_W = 5;
   localparam logic [4:0] LCGS_GATE_ONE_OFS = 5'h00;
   localparam logic [4:0] LCGS_GATE_TWO_OFS = 5'h04;
   localparam logic [4:0] LCGS_GATE_THREE_OFS = 5'h08;
   localparam logic [4:0] LCGS_GATE_FOUR_OFS = 5'h0c;
   localparam logic [4:0] LCGS_DATA_ONE_TWO_OFS = 5'h10;
   localparam logic [4:0] LCGS_DATA_THREE_FOUR_OFS = 5'h14;
   localparam logic [4:0] LCGS_GATE_STATE_OFS = 5'h18;
   localparam logic [7:0] LCGS_GATE_RESET = 8'h00;
   localparam logic [7:0] LCGS_SEL_RESET = 8'h00;
   localparam logic [7:0] LCGS_SEL_MASK = 8'h77;
   localparam int unsigned LCGS_SEL_LO_POS = 0;
   localparam int unsigned LCGS_SEL_HI_POS = 4;
   localparam logic [1:0] LCGS_HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] LCGS_HSIZE_WORD = 3'h2;
   typedef enum logic [0:0] {
      LCGS_IDLE = 1'b0,
      LCGS_DATA = 1'b1
   } lcgs_phase_t;
endpackage

// File: design/lcgs_regfile.sv
// register file of eight-bit words with registered read port
`timescale 1ns/1ns
module lcgs_regfile (
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // write port
   input wire logic wr_en,
   input wire logic [2:0] wr_idx,
   input wire logic [7:0] wr_data,
   // read port
   input wire logic [2:0] rd_idx,
   output logic [7:0] rd_data,
   // all words, flat
   output logic [47:0] words
);
   import lcgs_pkg::*;
   logic [7:0] mem_q [0:5];

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 6; i++) begin
            mem_q[i] <= LCGS_GATE_RESET;
         end
      end else if (wr_en && wr_idx < 3'h6) begin
         mem_q[wr_idx] <= wr_data;
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         rd_data <= 8'h00;
      end else if (rd_idx < 3'h6) begin
         rd_data <= mem_q[rd_idx];
      end else begin
         rd_data <= 8'h00;
      end
   end

   always_comb begin
      for (int i = 0; i < 6; i++) begin
         words[i*8 +: 8] = mem_q[i];
      end
   end
endmodule

// File: design/lcgs_top.sv
// gate-select stage of a configurable logic cell with ahb-lite registers
//
// Function
// (R01) gate one select register, d4t..d1n
// (R02) gate two select register, same order
// (R03) gate three select register, same order
// (R04) gate four select register, same order
// (R05) set bit admits signal, clear excludes
// (R06) select bits readable and writable
// (R07) three-bit selector picks one of eight inputs
// (R08) gate is or of enabled signals
//
// Local design decisions: the placing of the registers and the AHB-Lite slave port.
`timescale 1ns/1ns
module lcgs_top
   import lcgs_pkg::*;
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // ahb-lite slave
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   // cell input sources
   input wire logic [7:0] cell_input_source,
   // gate outputs
   output logic gate_one_out,
   output logic gate_two_out,
   output logic gate_three_out,
   output logic gate_four_out
);
   lcgs_phase_t phase_q;
   logic [2:0] idx_q;
   logic wr_q;
   logic wr_en;
   logic [7:0] wr_data;
   logic [2:0] rd_idx;
   logic [7:0] rd_data;
   logic [47:0] words;
   logic addr_ok;
   logic [3:0] data_true;
   logic [3:0] gates_d;
   logic [3:0] gates_q;

   function automatic logic [2:0] addr_idx(input logic [31:0] a);
      addr_idx = a[4:2];
   endfunction

   // d4t,d4n,d3t,d3n,d2t,d2n,d1t,d1n masked by select byte
   function automatic logic gate_or(input logic [7:0] sel, input logic [3:0] d);
      logic [7:0] both;
      both = {d[3], ~d[3], d[2], ~d[2], d[1], ~d[1], d[0], ~d[0]};
      gate_or = |(sel & both); // R05 R08
   endfunction

   assign addr_ok = hsel && hready && htrans == LCGS_HTRANS_NONSEQ && hsize == LCGS_HSIZE_WORD;

   // address phase capture
   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         phase_q <= LCGS_IDLE;
         idx_q <= 3'h0;
         wr_q <= 1'b0;
      end else if (addr_ok) begin
         phase_q <= LCGS_DATA;
         idx_q <= addr_idx(haddr);
         wr_q <= hwrite;
      end else begin
         phase_q <= LCGS_IDLE;
      end
   end

   // select bytes; selector words keep only their code fields
   assign wr_en = phase_q == LCGS_DATA && wr_q; // R06
   assign wr_data = idx_q >= 3'h4 ? (hwdata[7:0] & LCGS_SEL_MASK) : hwdata[7:0];
   assign rd_idx = addr_idx(haddr);

   lcgs_regfile u_regs (
      .core_clk(core_clk),
      .rstn(rstn),
      .wr_en(wr_en),
      .wr_idx(idx_q),
      .wr_data(wr_data),
      .rd_idx(rd_idx),
      .rd_data(rd_data),
      .words(words)
   );

   // read data: registered word or live gate state
   always_comb begin
      hrdata = 32'h0000_0000;
      if (phase_q == LCGS_DATA && !wr_q) begin
         if (idx_q == addr_idx({27'h0, LCGS_GATE_STATE_OFS})) begin
            hrdata = {28'h0, gates_q};
         end else begin
            hrdata = {24'h0, rd_data}; // R06
         end
      end
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // data selectors from cell inputs
   always_comb begin
      data_true[0] = cell_input_source[words[32 + LCGS_SEL_LO_POS +: 3]]; // R07
      data_true[1] = cell_input_source[words[32 + LCGS_SEL_HI_POS +: 3]]; // R07
      data_true[2] = cell_input_source[words[40 + LCGS_SEL_LO_POS +: 3]]; // R07
      data_true[3] = cell_input_source[words[40 + LCGS_SEL_HI_POS +: 3]]; // R07
   end

   always_comb begin
      gates_d[0] = gate_or(words[7:0], data_true); // R01
      gates_d[1] = gate_or(words[15:8], data_true); // R02
      gates_d[2] = gate_or(words[23:16], data_true); // R03
      gates_d[3] = gate_or(words[31:24], data_true); // R04
   end

   always_ff @(posedge core_clk or negedge rstn) begin
      if (!rstn) begin
         gates_q <= 4'h0;
      end else begin
         gates_q <= gates_d; // R08
      end
   end

   assign gate_one_out = gates_q[0];
   assign gate_two_out = gates_q[1];
   assign gate_three_out = gates_q[2];
   assign gate_four_out = gates_q[3];
endmodule

// File: verification/lcgs_props.sv
// port assertions for the gate-select block
`timescale 1ns/1ns
module lcgs_props (
   input wire logic core_clk, rstn, hsel, hwrite, hready, hreadyout, hresp,
   input wire logic [31:0] haddr, hrdata,
   input wire logic [1:0] htrans,
   input wire logic [2:0] hsize,
   input wire logic [7:0] cell_input_source,
   input wire logic gate_one_out, gate_two_out, gate_three_out, gate_four_out
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rstn);
   wire [3:0] g = {gate_four_out, gate_three_out, gate_two_out, gate_one_out};
   wire rd = hsel & hready & htrans[1] & !hwrite;
   wire w = hsel & htrans[1] & hwrite;
   a_rdy_high: assert property (hreadyout) else $error("wait");
   a_resp_okay: assert property (!hresp) else $error("resp");
   a_gate_reset: assert property ($rose(rstn) |-> !g) else $error("rst");
   a_upper_zero: assert property ($past(rd) |-> !hrdata[31:8]) else $error("hi");
   a_hole_zero: assert property ($past(rd && haddr[4:0] == 5'h1c) |-> !hrdata) else $error("map");
   a_narrow_zero: assert property ($past(rd && hsize != 3'h2) |-> !hrdata) else $error("size");
   a_pad_zero: assert property ($past(rd && haddr[4:3] == 2'h2) |-> !(hrdata & 32'h88)) else $error("pad");
   a_gate_hold: assert property (!w ##2 $stable(cell_input_source) |=> $stable(g)) else $error("gate");
   cover property (rd && hsize != 3'h2);
   cover property (w);
   cover property ($rose(gate_four_out));
endmodule
bind lcgs_top lcgs_props u_props (.*);

// File: verification/lcgs_src_model.sv
// input selection stage feeding the cell sources
`timescale 1ns/1ns
module lcgs_src_model (
   input wire logic core_clk,
   input wire logic [7:0] pattern,
   output logic [7:0] cell_input_source
);
   always_ff @(posedge core_clk) cell_input_source <= pattern;
endmodule

// File: verification/test_lcgs_top.sv
// bench for the gate-select block
`timescale 1ns/1ns
module test_lcgs_top;
   logic core_clk = 0, rstn = 0, hsel = 0, hwrite = 0;
   logic [1:0] htrans = 2'h0;
   logic [2:0] hsize = 3'h2;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
   logic [7:0] pat = 0, src, s;
   logic [3:0] ge;
   logic hreadyout, hresp;
   wire [3:0] gv;
   int miscompares = 0, comparisons = 0;
   logic [39:0] tbl [3] = '{40'h00000000a5, 40'hff8001423c, 40'h2008c01196};
   always #2 core_clk = ~core_clk;
   lcgs_src_model u_src (.core_clk, .pattern(pat), .cell_input_source(src));
   lcgs_top u_dut (.core_clk, .rstn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout),
      .hrdata, .hreadyout, .hresp, .cell_input_source(src), .gate_one_out(gv[0]), .gate_two_out(gv[1]),
      .gate_three_out(gv[2]), .gate_four_out(gv[3]));
   task close_out;
      $display("miscompares %0d comparisons %0d", miscompares, comparisons);
      if (miscompares == 0 && comparisons > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] got, exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("Error %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task hop;
      int n;
      logic rdy;
      n = 0;
      do begin
         @(negedge core_clk);
         rdy = hreadyout;
         rd = hrdata;
         @(posedge core_clk);
         n++;
      end while (rdy !== 1'b1 && n < 50);
      if (rdy !== 1'b1) begin
         miscompares++;
         close_out;
      end
   endtask
   task bus(input logic w, input logic [4:0] a, input logic [7:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {27'h0, a};
      hop;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      hop;
   endtask
   function logic ex(input logic [7:0] g, s0, s1, p);
      logic [3:0] d;
      d = {p[s1[6:4]], p[s1[2:0]], p[s0[6:4]], p[s0[2:0]]};
      return |(g & {d[3], !d[3], d[2], !d[2], d[1], !d[1], d[0], !d[0]});
   endfunction
   initial begin
      repeat (20) @(posedge core_clk);
      rstn <= 1'b1;
      for (int k = 0; k < 8; k++) begin
         for (int r = 0; r < 3; r++) begin
            s = {1'b0, k[2:0], 1'b0, ~k[2:0]};
            bus(1'b1, 5'h10, s);
            bus(1'b1, 5'h14, s ^ 8'h33);
            for (int j = 0; j < 4; j++) bus(1'b1, 5'(4 * j), tbl[r][39 - 8 * j -: 8]);
            pat <= tbl[r][7:0];
            repeat (3) @(posedge core_clk);
            for (int j = 0; j < 4; j++) chk(32'(gv[j]), 32'(ex(tbl[r][39 - 8 * j -: 8], s, s ^ 8'h33, pat)));
            bus(1'b0, 5'(4 * r), 8'h0);
            chk(rd, {24'h0, tbl[r][39 - 8 * r -: 8]});
            for (int j = 0; j < 4; j++) ge[j] = ex(tbl[r][39 - 8 * j -: 8], s, s ^ 8'h33, pat);
            bus(1'b0, 5'h18, 8'h0);
            chk(rd, {28'h0, ge});
         end
      end
      hsize <= 3'h0;
      bus(1'b1, 5'h0, 8'hff);
      bus(1'b0, 5'h0, 8'h0);
      chk(rd, 0);
      hsize <= 3'h2;
      bus(1'b0, 5'h0, 8'h0);
      chk(rd, {24'h0, tbl[2][39:32]});
      bus(1'b0, 5'h1c, 8'h0);
      chk(rd, 0);
      rstn <= 1'b0;
      @(posedge core_clk);
      rstn <= 1'b1;
      bus(1'b0, 5'hc, 8'h0);
      chk(rd, 0);
      chk(32'(gv), 0);
      chk({31'h0, hresp}, 0);
      close_out;
   end
endmodule
